// ### core/arb_pkg.sv
// Shared types and constants for the per-card backplane bus arbiter
package arb_pkg;

    // Backplane access controller states
    typedef enum logic [1:0] {
        BAC_IDLE,
        BAC_REQUESTING,
        BAC_GRANT
    } bac_state_t;

    // Local request controller states
    typedef enum logic [1:0] {
        LRC_LOCAL,
        LRC_REQUESTING,
        LRC_BUS_OWNER,
        LRC_RELEASING
    } lrc_state_t;

    // Backplane lines as seen by this card, all on the arbitration clock
    typedef struct packed {
        logic requesting_state_n;  // Wired bus request line level, active low
        logic busak_n;  // Wired bus acknowledge line level, active low
        logic pci;      // Priority chain in, active high
    } bp_in_t;

    // Backplane drive from this card
    typedef struct packed {
        logic requesting_state_o;     // Request line output value (low when driving)
        logic requesting_state_oe_n;  // Request line enable, low while driving
        logic busak_o;     // Acknowledge line output value
        logic busak_oe_n;  // Acknowledge line enable, low while driving
        logic pco;         // Priority chain out
    } bp_out_t;

    // Reset values
    localparam logic PORT_LOCK_RESET = 1'b1;        // Host takes the bus after reset
    localparam logic SYNC_RESET = 1'b0;             // Synchroniser flops
    localparam logic FLAG_RESET = 1'b0;             // Off-card access flag
    localparam bac_state_t BAC_RESET = BAC_REQUESTING;
    localparam lrc_state_t LRC_RESET = LRC_REQUESTING;

    // Open-collector drive levels
    localparam logic LINE_DRIVE_LOW = 1'b0;         // Value put on a driven line
    localparam logic OE_ON = 1'b0;                  // Enable level while driving
    localparam logic OE_OFF = 1'b1;                 // Enable level while released

endpackage

// ### core/multiprocessor_bus_arbiter.sv
// Per-card backplane bus arbiter: access controller, request controller and CPU sync
`timescale 1ns/1ps
`default_nettype none

module multiprocessor_bus_arbiter #(
    parameter bit HOST_CARD = 1'b0  // Set on the highest-priority card
) (
    input wire logic clock,                    // Processor-side clock, 125 MHz
    input wire logic rst_n,                    // Synchronous reset, active low
    input wire logic arb_clk,                  // Backplane arbitration clock
    input wire arb_pkg::bp_in_t bp_in,         // Backplane line levels
    output var arb_pkg::bp_out_t bp_out,       // Backplane drive
    input wire logic offcard_access_decode,    // Address decodes off-card, level
    input wire logic addr_stable,              // Pulse at end of address strobe
    input wire logic cycle_done,               // Pulse when off-card cycle ends
    input wire logic cpu_lock_n,               // Processor locked-cycle line, active low
    input wire logic lock_wr,                  // Pulse: write port lock bit
    input wire logic lock_wdata,               // Value for port lock bit
    output logic cpu_ready,                    // Ready to processor, low stalls
    output logic port_lock_bit,                // Port lock bit readback
    output logic bus_available_flag            // Status: this card owns the bus
);

    // ---------------- Processor clock domain ----------------

    logic port_lock_q;              // Port lock bit
    logic access_synced_q;          // Deglitched off-card access flag
    logic owner_s1_q;               // Owner flag sync, first stage
    logic owner_s2_q;               // Owner flag sync, second stage
    logic requesting_state_s1_q;               // Foreign request sync, first stage
    logic requesting_state_s2_q;               // Foreign request sync, second stage
    logic unlocked_q;               // Unlocked foreign request
    logic unlocked_d;               // Next unlocked foreign request
    logic offcard_access_synced;    // Request level handed to the link side
    logic lock_any;                 // Any reason to keep the bus
    logic requesting_state_seen_q;             // Request line active, registered on the link side
    logic owner_link_q;             // Request controller in owner state, link side

    // Port lock bit; reset sets it so the host grabs and keeps the bus
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            port_lock_q <= arb_pkg::PORT_LOCK_RESET;
        end
        else if (lock_wr)
        begin
            port_lock_q <= lock_wdata;
        end
    end

    // Off-card access flag: set once the address is stable, cleared when the
    // cycle completes; a new access in the clearing cycle wins
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            access_synced_q <= arb_pkg::FLAG_RESET;
        end
        else if (addr_stable && offcard_access_decode)
        begin
            access_synced_q <= 1'b1;
        end
        else if (cycle_done)
        begin
            access_synced_q <= 1'b0;
        end
    end

    // Bring the owner state and the request line into the processor clock
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            owner_s1_q <= arb_pkg::SYNC_RESET;
            owner_s2_q <= arb_pkg::SYNC_RESET;
            requesting_state_s1_q <= arb_pkg::SYNC_RESET;
            requesting_state_s2_q <= arb_pkg::SYNC_RESET;
        end
        else
        begin
            owner_s1_q <= owner_link_q;
            owner_s2_q <= owner_s1_q;
            requesting_state_s1_q <= requesting_state_seen_q;
            requesting_state_s2_q <= requesting_state_s1_q;
        end
    end

    // Lock covers an off-card cycle in flight, locked instructions and the
    // port lock bit; release in the middle of a cycle would hang the CPU
    assign lock_any = port_lock_q || !cpu_lock_n || access_synced_q;

    // Foreign request only counts while we own the bus and hold no lock
    assign unlocked_d = requesting_state_s2_q && !lock_any && owner_s2_q;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            unlocked_q <= 1'b0;
        end
        else
        begin
            unlocked_q <= unlocked_d;
        end
    end

    // Port lock alone asks for the bus, without any CPU wait
    assign offcard_access_synced = access_synced_q || port_lock_q;

    // Stall only a processor that wants the bus and lacks it
    assign cpu_ready = !(access_synced_q && !owner_s2_q);
    assign bus_available_flag = owner_s2_q;
    assign port_lock_bit = port_lock_q;

    // ---------------- Arbitration clock domain ----------------

    logic lrst_s1_q;                // Reset sync, first stage
    logic link_rst_n;               // Reset sync, second stage
    logic req_s1_q;                 // Request level sync, first stage
    logic req_s2_q;                 // Request level sync, second stage
    logic unl_s1_q;                 // Unlocked request sync, first stage
    logic unl_s2_q;                 // Unlocked request sync, second stage
    arb_pkg::bac_state_t bac_q;     // Access controller state
    arb_pkg::bac_state_t bac_d;     // Next access controller state
    arb_pkg::lrc_state_t lrc_q;     // Request controller state
    arb_pkg::lrc_state_t lrc_d;     // Next request controller state
    logic pci_eff;                  // Chain in after host override
    logic requesting_state_active;             // Request line pulled low by anyone
    logic busak_active;             // Acknowledge line pulled low by anyone
    logic bac_request;              // Request into access controller
    logic bac_release;              // Release into access controller
    logic bac_grant;                // Grant out of access controller
    logic ack_drive_enable;         // Permission to drive acknowledge

    // Reset and CPU-side levels are resampled on the rising edge so that
    // they are settled half a period before the falling edge that uses them;
    // this is how the asynchronous entries are brought in without a raw path
    always_ff @(posedge arb_clk)
    begin
        lrst_s1_q <= rst_n;
        link_rst_n <= lrst_s1_q;
        req_s1_q <= offcard_access_synced;
        req_s2_q <= req_s1_q;
        unl_s1_q <= unlocked_q;
        unl_s2_q <= unl_s1_q;
    end

    assign pci_eff = HOST_CARD ? 1'b1 : bp_in.pci;
    assign requesting_state_active = !bp_in.requesting_state_n;
    assign busak_active = !bp_in.busak_n;

    // Access controller next state
    always_comb
    begin
        bac_d = bac_q;
        case (bac_q)
            arb_pkg::BAC_IDLE:
            begin
                // Join only when no arbitration is under way, so a queue
                // formed in one period drains before newcomers enter
                if (bac_request && !requesting_state_active)
                begin
                    bac_d = arb_pkg::BAC_REQUESTING;
                end
            end
            arb_pkg::BAC_REQUESTING:
            begin
                // Wait for higher priority to clear and the old owner to drop
                if (pci_eff && !busak_active)
                begin
                    bac_d = arb_pkg::BAC_GRANT;
                end
            end
            arb_pkg::BAC_GRANT:
            begin
                if (bac_release)
                begin
                    bac_d = arb_pkg::BAC_IDLE;
                end
            end
            default:
            begin
                bac_d = arb_pkg::BAC_IDLE;
            end
        endcase
    end

    // Access controller state register, falling edge only
    always_ff @(negedge arb_clk)
    begin
        if (!link_rst_n)
        begin
            bac_q <= arb_pkg::BAC_RESET;
        end
        else
        begin
            bac_q <= bac_d;
        end
    end

    assign bac_grant = (bac_q == arb_pkg::BAC_GRANT);

    // Request controller next state
    always_comb
    begin
        lrc_d = lrc_q;
        case (lrc_q)
            arb_pkg::LRC_LOCAL:
            begin
                if (req_s2_q)
                begin
                    lrc_d = arb_pkg::LRC_REQUESTING;
                end
            end
            arb_pkg::LRC_REQUESTING:
            begin
                if (bac_grant)
                begin
                    lrc_d = arb_pkg::LRC_BUS_OWNER;
                end
            end
            arb_pkg::LRC_BUS_OWNER:
            begin
                // Stay owner until a foreign request; repeat accesses are free
                if (unl_s2_q)
                begin
                    lrc_d = arb_pkg::LRC_RELEASING;
                end
            end
            arb_pkg::LRC_RELEASING:
            begin
                if (!bac_grant)
                begin
                    lrc_d = arb_pkg::LRC_LOCAL;
                end
            end
            default:
            begin
                lrc_d = arb_pkg::LRC_LOCAL;
            end
        endcase
    end

    // Request controller state register
    always_ff @(negedge arb_clk)
    begin
        if (!link_rst_n)
        begin
            lrc_q <= arb_pkg::LRC_RESET;
        end
        else
        begin
            lrc_q <= lrc_d;
        end
    end

    // Asynchronous entries act on the outputs at once, ahead of the edge
    assign bac_request = (lrc_q == arb_pkg::LRC_REQUESTING)
        || ((lrc_q == arb_pkg::LRC_LOCAL) && req_s2_q);
    assign bac_release = (lrc_q == arb_pkg::LRC_RELEASING)
        || ((lrc_q == arb_pkg::LRC_BUS_OWNER) && unl_s2_q);
    assign ack_drive_enable = (lrc_q == arb_pkg::LRC_BUS_OWNER)
        || (lrc_q == arb_pkg::LRC_RELEASING);

    // Owner flag and request line snapshot handed to the processor side
    always_ff @(negedge arb_clk)
    begin
        if (!link_rst_n)
        begin
            owner_link_q <= 1'b0;
            requesting_state_seen_q <= 1'b0;
        end
        else
        begin
            owner_link_q <= (lrc_d == arb_pkg::LRC_BUS_OWNER);
            requesting_state_seen_q <= requesting_state_active;
        end
    end

    // Backplane drive: request and acknowledge lines are only ever pulled low, never driven high,
    // so any number of cards may assert them together; chain out is driven both high and low
    always_comb
    begin
        bp_out.requesting_state_o = arb_pkg::LINE_DRIVE_LOW;
        bp_out.busak_o = arb_pkg::LINE_DRIVE_LOW;
        bp_out.requesting_state_oe_n = arb_pkg::OE_OFF;
        bp_out.busak_oe_n = arb_pkg::OE_OFF;
        bp_out.pco = pci_eff;
        if (bac_q == arb_pkg::BAC_REQUESTING)
        begin
            bp_out.requesting_state_oe_n = arb_pkg::OE_ON;
            bp_out.pco = 1'b0;
        end
        else if (bac_q == arb_pkg::BAC_GRANT && ack_drive_enable)
        begin
            bp_out.busak_oe_n = arb_pkg::OE_ON;
        end
    end

    // ---------------- Checks ----------------

    sequence s_release_seen;
        bac_q == arb_pkg::BAC_GRANT && bac_release;
    endsequence

    sequence s_releasing_grant_gone;
        lrc_q == arb_pkg::LRC_RELEASING && !bac_grant;
    endsequence

    AST_REQ_DRIVE: assert property (@(negedge arb_clk) disable iff (!link_rst_n)
        bac_q == arb_pkg::BAC_REQUESTING |-> !bp_out.pco && bp_out.requesting_state_oe_n == arb_pkg::OE_ON)
        else $error("requesting state must drive request and lower chain out");

    AST_REQ_HOLD: assert property (@(negedge arb_clk) disable iff (!link_rst_n)
        bac_q == arb_pkg::BAC_REQUESTING && !(pci_eff && !busak_active)
        |=> bac_q == arb_pkg::BAC_REQUESTING)
        else $error("left requesting state without chain in and free acknowledge");

    AST_GRANT_OUT: assert property (@(negedge arb_clk) disable iff (!link_rst_n)
        bac_q == arb_pkg::BAC_GRANT |-> bp_out.pco == pci_eff && bac_grant
        && bp_out.requesting_state_oe_n == arb_pkg::OE_OFF)
        else $error("grant state outputs wrong");

    AST_IDLE_QUIET: assert property (@(negedge arb_clk) disable iff (!link_rst_n)
        bac_q == arb_pkg::BAC_IDLE |-> bp_out.pco == pci_eff
        && bp_out.requesting_state_oe_n == arb_pkg::OE_OFF && bp_out.busak_oe_n == arb_pkg::OE_OFF)
        else $error("idle state drives the backplane");

    AST_GRANT_RELEASE: assert property (@(negedge arb_clk) disable iff (!link_rst_n)
        s_release_seen |=> bac_q == arb_pkg::BAC_IDLE ##1 !ack_drive_enable || bac_request)
        else $error("release did not return controller to idle");

    AST_RELEASE_LOCAL: assert property (@(negedge arb_clk) disable iff (!link_rst_n)
        s_releasing_grant_gone |=> lrc_q == arb_pkg::LRC_LOCAL || lrc_q == arb_pkg::LRC_REQUESTING)
        else $error("releasing state did not end after grant dropped");

    AST_HOST_CHAIN: assert property (@(negedge arb_clk) disable iff (!link_rst_n)
        HOST_CARD |-> pci_eff)
        else $error("host card must see chain in active");

    AST_JOIN_QUEUE: assert property (@(negedge arb_clk) disable iff (!link_rst_n)
        bac_q == arb_pkg::BAC_IDLE && requesting_state_active |=> bac_q != arb_pkg::BAC_REQUESTING)
        else $error("joined arbitration already under way");

    AST_CPU_STALL: assert property (@(posedge clock) disable iff (!rst_n)
        access_synced_q && !owner_s2_q |-> !cpu_ready)
        else $error("processor not stalled without the bus");

    AST_LOCK_RESET: assert property (@(posedge clock)
        !rst_n |=> port_lock_q ##1 port_lock_q || $past(lock_wr))
        else $error("reset did not set the port lock bit");

    AST_UNLOCK_OWNER: assert property (@(posedge clock) disable iff (!rst_n)
        unlocked_q |-> $past(owner_s2_q) && !$past(port_lock_q))
        else $error("unlocked foreign request outside owner state or under lock");

endmodule

`default_nettype wire

// ### test/backplane_card_model.sv
// Behavioural model of one lower-priority card sharing the backplane
`timescale 1ns/1ps
`default_nettype none

module backplane_card_model #(
    parameter int HOLD = 2  // Falling edges kept after a foreign request is seen
) (
    input wire logic arb_clk,  // Arbitration clock
    input wire logic rst_n,    // Reset, active low
    input wire logic want,     // Bench asks this card to seek the bus
    input wire logic pci,      // Priority chain in, from the card on the right
    input wire logic requesting_state_n,  // Resolved request line
    input wire logic busak_n,  // Resolved acknowledge line
    output logic rq_pull,      // High while pulling the request line low
    output logic ak_pull,      // High while pulling the acknowledge line low
    output logic owns          // This card holds the bus
);
    logic [1:0] st_q;  // 0 idle, 1 requesting, 2 owner
    int hold_q;        // Edges spent owning while another card waits

    // Card state, moved on the falling arbitration edge like the real arbiter
    always_ff @(negedge arb_clk)
    begin
        if (!rst_n)
        begin
            st_q <= 2'h0;
            hold_q <= 0;
        end
        else if (st_q == 2'h0)
        begin
            // Join only while no arbitration is under way
            if (want && requesting_state_n)
                st_q <= 2'h1;
        end
        else if (st_q == 2'h1)
        begin
            // Higher card quiet and previous owner gone
            if (pci && busak_n)
                st_q <= 2'h2;
        end
        else
        begin
            // Latched ownership, yielded a little after a foreign request
            if (!requesting_state_n)
                hold_q <= hold_q + 1;
            if (hold_q >= HOLD)
            begin
                st_q <= 2'h0;
                hold_q <= 0;
            end
        end
    end

    // Open-collector pulls: released lines float to the pull-up
    assign rq_pull = (st_q == 2'h1);
    assign ak_pull = (st_q == 2'h2);
    assign owns = ak_pull;
endmodule

`default_nettype wire

// ### test/multiprocessor_bus_arbiter_tb.sv
// Self-checking bench for the per-card backplane bus arbiter
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
    begin \
        tests_run++; \
        if ((got) !== (ex)) \
        begin \
            bad_count++; \
            $display("BAD %s expected %0h seen %0h", nm, ex, got); \
        end \
    end

module multiprocessor_bus_arbiter_tb;
    logic clock;  // Processor clock, 8 ns
    logic arb_clk;  // Arbitration clock, 6 ns, free running
    logic rst_n;  // Reset, active low
    logic pci_d;  // Chain level from the card to our right
    logic decode;  // Off-card decode level
    logic astb;  // Address stable pulse
    logic done;  // Off-card cycle done pulse
    logic lock_n;  // Processor locked cycle, active low
    logic lk_wr;  // Port lock write pulse
    logic lk_d;  // Port lock write data
    logic want;  // Other card seeks the bus
    logic rq_pull;  // Other card pulls request
    logic ak_pull;  // Other card pulls acknowledge
    logic owns;  // Other card holds the bus
    logic rq_line;  // Resolved request line
    logic ak_line;  // Resolved acknowledge line
    logic cpu_ready;  // Processor ready
    logic port_lock_bit;  // Port lock readback
    logic bus_available_flag;  // Card owns the bus
    arb_pkg::bp_in_t bp_in;  // Lines seen by the card
    arb_pkg::bp_out_t bp_out;  // Card drive
    arb_pkg::bp_in_t h_in;  // Lines seen by the lone host card
    arb_pkg::bp_out_t h_out;  // Host card drive
    logic h_flag;  // Host card owns the bus
    int bad_count;  // Mismatches
    int tests_run;  // Comparisons

    // Wired-OR resolution: any enabled driver pulls the line low
    assign rq_line = !(((bp_out.requesting_state_oe_n == arb_pkg::OE_ON) && !bp_out.requesting_state_o) || rq_pull);
    assign ak_line = !(((bp_out.busak_oe_n == arb_pkg::OE_ON) && !bp_out.busak_o) || ak_pull);
    assign bp_in = {rq_line, ak_line, pci_d};

    multiprocessor_bus_arbiter #(.HOST_CARD(1'b0)) i_dut (
        .clock(clock),
        .rst_n(rst_n),
        .arb_clk(arb_clk),
        .bp_in(bp_in),
        .bp_out(bp_out),
        .offcard_access_decode(decode),
        .addr_stable(astb),
        .cycle_done(done),
        .cpu_lock_n(lock_n),
        .lock_wr(lk_wr),
        .lock_wdata(lk_d),
        .cpu_ready(cpu_ready),
        .port_lock_bit(port_lock_bit),
        .bus_available_flag(bus_available_flag)
    );

    // Lone host card: only its own pulls on the lines, chain in held inactive
    assign h_in = {!((h_out.requesting_state_oe_n == arb_pkg::OE_ON) && !h_out.requesting_state_o),
        !((h_out.busak_oe_n == arb_pkg::OE_ON) && !h_out.busak_o), 1'b0};

    multiprocessor_bus_arbiter #(.HOST_CARD(1'b1)) i_host (
        .clock(clock),
        .rst_n(rst_n),
        .arb_clk(arb_clk),
        .bp_in(h_in),
        .bp_out(h_out),
        .offcard_access_decode(1'b0),
        .addr_stable(1'b0),
        .cycle_done(1'b0),
        .cpu_lock_n(1'b1),
        .lock_wr(1'b0),
        .lock_wdata(1'b0),
        .cpu_ready(),
        .port_lock_bit(),
        .bus_available_flag(h_flag)
    );

    // The other card's chain input is our chain output
    backplane_card_model #(.HOLD(2)) i_card (
        .arb_clk(arb_clk),
        .rst_n(rst_n),
        .want(want),
        .pci(bp_out.pco),
        .requesting_state_n(rq_line),
        .busak_n(ak_line),
        .rq_pull(rq_pull),
        .ak_pull(ak_pull),
        .owns(owns)
    );

    // Processor clock
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Arbitration clock, offset so its edges never meet the processor's
    initial
    begin
        arb_clk = 1'b0;
        #1.7;
        forever #3 arb_clk = ~arb_clk;
    end

    // Inputs always move 1 ns after a processor edge
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Counts, verdict and end of run
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Bounded wait: 0 ownership flag, 1 ready, 2 other card owning
    task automatic wait_sig(input int which, input logic v);
        int n;
        logic s;
        n = 0;
        s = ~v;
        while (s !== v && n < 400)
        begin
            step(1);
            n++;
            s = (which == 0) ? bus_available_flag : (which == 1) ? cpu_ready : owns;
        end
        if (s !== v)
        begin
            bad_count++;
            $display("BAD wait %0d expected %0h seen %0h", which, v, s);
            wrap_up();
        end
    endtask

    // Reset state, blocked grant, then grant once the chain allows
    task automatic t_reset();
        `CHK("rst_rq_oe", arb_pkg::OE_ON, bp_out.requesting_state_oe_n)
        `CHK("rst_lock", 1'b1, port_lock_bit)
        rst_n = 1'b1;
        step(20);
        `CHK("blk_rq_oe", arb_pkg::OE_ON, bp_out.requesting_state_oe_n)
        `CHK("blk_pco", 1'b0, bp_out.pco)
        `CHK("blk_flag", 1'b0, bus_available_flag)
        `CHK("host_flag", 1'b1, h_flag)
        `CHK("host_ak_oe", arb_pkg::OE_ON, h_out.busak_oe_n)
        pci_d = 1'b1;
        wait_sig(0, 1'b1);
        `CHK("gnt_ak_oe", arb_pkg::OE_ON, bp_out.busak_oe_n)
        `CHK("gnt_rq_oe", arb_pkg::OE_OFF, bp_out.requesting_state_oe_n)
        `CHK("gnt_pco", pci_d, bp_out.pco)
        $display("test reset done");
    endtask

    // Port lock holds off a foreign request until cleared
    task automatic t_lock_bit();
        want = 1'b1;
        step(100);
        `CHK("plk_flag", 1'b1, bus_available_flag)
        `CHK("plk_other", 1'b0, owns)
        lk_d = 1'b0;
        lk_wr = 1'b1;
        step(1);
        lk_wr = 1'b0;
        `CHK("plk_clear", 1'b0, port_lock_bit)
        wait_sig(0, 1'b0);
        wait_sig(2, 1'b1);
        want = 1'b0;
        `CHK("idle_ak_oe", arb_pkg::OE_OFF, bp_out.busak_oe_n)
        `CHK("idle_rq_oe", arb_pkg::OE_OFF, bp_out.requesting_state_oe_n)
        `CHK("idle_pco", pci_d, bp_out.pco)
        `CHK("idle_ready", 1'b1, cpu_ready)
        $display("test port lock done");
    endtask

    // Off-card access stalls, wins the bus, then keeps it
    task automatic t_access();
        decode = 1'b1;
        astb = 1'b1;
        step(1);
        astb = 1'b0;
        `CHK("acc_stall", 1'b0, cpu_ready)
        wait_sig(1, 1'b1);
        `CHK("acc_flag", 1'b1, bus_available_flag)
        `CHK("acc_other", 1'b0, owns)
        done = 1'b1;
        step(1);
        done = 1'b0;
        decode = 1'b0;
        step(50);
        `CHK("acc_keep", 1'b1, bus_available_flag)
        $display("test access done");
    endtask

    // Processor locked cycle blocks release until it ends
    task automatic t_cpu_lock();
        lock_n = 1'b0;
        want = 1'b1;
        step(100);
        `CHK("clk_hold", 1'b1, bus_available_flag)
        lock_n = 1'b1;
        wait_sig(0, 1'b0);
        wait_sig(2, 1'b1);
        want = 1'b0;
        `CHK("clk_ready", 1'b1, cpu_ready)
        $display("test locked cycle done");
    endtask

    // Main sequence
    initial
    begin
        bad_count = 0;
        tests_run = 0;
        rst_n = 1'b0;
        pci_d = 1'b0;
        decode = 1'b0;
        astb = 1'b0;
        done = 1'b0;
        lock_n = 1'b1;
        lk_wr = 1'b0;
        lk_d = 1'b0;
        want = 1'b0;
        step(5);
        t_reset();
        t_lock_bit();
        t_access();
        t_cpu_lock();
        wrap_up();
    end
endmodule

`default_nettype wire
